/* rtl/fpe_flash_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_ctrl #(
    parameter int unsigned CLK_KHZ = fpe_pkg::BUS_CLK_KHZ,
    parameter logic [15:0] BOUNDARY_ADDR = fpe_pkg::BOUNDARY_ADDR_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fpe_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic lowpower_req,
    input wire logic test_high_voltage,
    // array control
    output logic pump_on,
    output logic hv_to_array,
    output logic erase_page_en,
    output logic erase_mass_en,
    output logic trim_erase,
    output logic program_en,
    output logic prog_strobe,
    output logic [15:0] array_addr,
    output logic [7:0] array_data,
    output logic standby
);
    import fpe_pkg::*;

    localparam logic [TMR_W-1:0] NVS_CYC = TMR_W'(fpe_us_to_cyc(SEL_TO_HV_DELAY_US, CLK_KHZ));
    localparam logic [TMR_W-1:0] PGS_CYC =
        TMR_W'(fpe_us_to_cyc(HV_TO_FIRST_WRITE_DELAY_US, CLK_KHZ));

    logic [1:0] lp_sync_ff;
    logic [1:0] tv_sync_ff;
    logic lp;
    logic tv;
    logic program_ff;
    logic erase_ff;
    logic mass_ff;
    logic hv_ff;
    logic [7:0] protect_ff;
    logic [15:0] target_ff;
    logic vec_page_ff;
    fpe_state_t state_ff;
    fpe_state_t nxt_state;
    logic [31:0] prdata_ff;
    logic prog_strobe_ff;
    logic [15:0] array_addr_ff;
    logic [7:0] array_data_ff;
    logic [TMR_W-1:0] elapsed;
    logic acc;
    logic mapped;
    logic wr_ctrl;
    logic wr_prot;
    logic wr_array;
    logic rd_prot;
    logic [15:0] wr_addr;
    logic w_pgm;
    logic w_erase;
    logic w_mass;
    logic w_hv;
    logic sel_ok;
    logic nxt_pgm;
    logic nxt_erase;
    logic hv_ok;
    logic target_prot;
    logic wr_prot_hit;
    logic mass_inhibit;
    logic prog_go;
    logic [31:0] rd_mux;

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_sync_ff <= 2'h0;
            tv_sync_ff <= 2'h0;
        end else begin
            lp_sync_ff <= {lp_sync_ff[0], lowpower_req};
            tv_sync_ff <= {tv_sync_ff[0], test_high_voltage};
        end
    end
    assign lp = lp_sync_ff[1];
    assign tv = tv_sync_ff[1];

    // apb decode
    assign acc = psel && penable;
    assign mapped = (paddr == FLASH_OP_CONTROL_OFS) || (paddr == PROTECT_START_SETTING_OFS) ||
        (paddr == ARRAY_WRITE_OFS) || (paddr == OP_STATUS_OFS) || (paddr == ELAPSED_OFS);
    assign wr_ctrl = acc && pwrite && (paddr == FLASH_OP_CONTROL_OFS);
    assign wr_prot = acc && pwrite && (paddr == PROTECT_START_SETTING_OFS);
    assign wr_array = acc && pwrite && (paddr == ARRAY_WRITE_OFS);
    assign rd_prot = acc && !pwrite && (paddr == PROTECT_START_SETTING_OFS);
    assign wr_addr = pwdata[AW_ADDR_LSB +: 16];
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    assign w_pgm = pwdata[CTRL_PROGRAM_SELECT_BIT];
    assign w_erase = pwdata[CTRL_ERASE_SELECT_BIT];
    assign w_mass = pwdata[CTRL_MASS_SELECT_BIT];
    assign w_hv = pwdata[CTRL_HIGH_VOLTAGE_ON_BIT];
    assign sel_ok = !(w_pgm && w_erase);
    assign nxt_pgm = sel_ok ? w_pgm : program_ff;
    assign nxt_erase = sel_ok ? w_erase : erase_ff;

    // protection of latched target and of the written address
    fpe_protect_decode #(
        .BOUNDARY_ADDR(BOUNDARY_ADDR)
    ) u_target_prot (
        .protect_start_bits(protect_ff),
        .addr(target_ff),
        .test_hv(tv),
        .addr_protected(target_prot),
        .mass_inhibit(mass_inhibit)
    );
    fpe_protect_decode #(
        .BOUNDARY_ADDR(BOUNDARY_ADDR)
    ) u_write_prot (
        .protect_start_bits(protect_ff),
        .addr(wr_addr),
        .test_hv(tv),
        .addr_protected(wr_prot_hit),
        .mass_inhibit()
    );

    // high voltage acceptance
    assign hv_ok = (state_ff == ST_ARMED) && (elapsed >= NVS_CYC) &&
        (nxt_pgm || nxt_erase) && (nxt_pgm == program_ff) && (nxt_erase == erase_ff) &&
        !target_prot && !(nxt_erase && w_mass && mass_inhibit);

    // flash_op_control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_ff <= 1'b0;
            erase_ff <= 1'b0;
            mass_ff <= 1'b0;
            hv_ff <= 1'b0;
        end else if (lp) begin
            program_ff <= 1'b0;
            erase_ff <= 1'b0;
            mass_ff <= 1'b0;
            hv_ff <= 1'b0;
        end else if (wr_ctrl) begin
            program_ff <= nxt_pgm;
            erase_ff <= nxt_erase;
            mass_ff <= w_mass;
            hv_ff <= w_hv && (hv_ff || hv_ok);
        end
    end

    // sequence tracking
    always_comb begin
        nxt_state = state_ff;
        if (lp) begin
            nxt_state = ST_IDLE;
        end else if (wr_ctrl) begin
            if (!hv_ff && w_hv && hv_ok) begin
                nxt_state = ST_HV_ON;
            end else if (hv_ff && w_hv) begin
                nxt_state = state_ff;
            end else if (!nxt_pgm && !nxt_erase) begin
                nxt_state = ST_IDLE;
            end else if ((nxt_pgm != program_ff) || (nxt_erase != erase_ff) || hv_ff) begin
                nxt_state = ST_SELECTED;
            end
        end else begin
            unique case (state_ff)
                ST_SELECTED: begin
                    if (rd_prot) begin
                        nxt_state = ST_PROT_READ;
                    end
                end
                ST_PROT_READ: begin
                    if (wr_array) begin
                        nxt_state = ST_ARMED;
                    end
                end
                ST_IDLE, ST_ARMED, ST_HV_ON: begin
                    nxt_state = state_ff;
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // interval timer restarts on each step and each byte
    fpe_interval_timer #(
        .W(TMR_W)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart((nxt_state != state_ff) || prog_go),
        .count(elapsed)
    );

    // program byte accepted
    assign prog_go = wr_array && !lp && (state_ff == ST_HV_ON) && hv_ff && program_ff &&
        (elapsed >= PGS_CYC) &&
        (wr_addr[15:ROW_LSB] == target_ff[15:ROW_LSB]) && !wr_prot_hit;

    // dummy write latches target, vector page flag and page or row base, never programs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_ff <= 16'h0000;
            vec_page_ff <= 1'b0;
        end else if (wr_array && (state_ff == ST_PROT_READ) && !lp) begin
            target_ff <= wr_addr;
            vec_page_ff <= (wr_addr >= VECTOR_PAGE_BASE);
        end
    end

    // array address and data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            array_addr_ff <= 16'h0000;
            array_data_ff <= 8'hff;
            prog_strobe_ff <= 1'b0;
        end else begin
            prog_strobe_ff <= prog_go;
            if (prog_go) begin
                array_addr_ff <= wr_addr;
                array_data_ff <= pwdata[AW_DATA_LSB +: 8];
            end else if (wr_array && (state_ff == ST_PROT_READ) && !lp) begin
                if (erase_ff) begin
                    array_addr_ff <= (wr_addr >= VECTOR_PAGE_BASE) ? VECTOR_PAGE_BASE :
                        {wr_addr[15:PAGE_LSB], 6'h00};
                end else begin
                    array_addr_ff <= {wr_addr[15:ROW_LSB], 5'h00};
                end
            end
        end
    end

    // boundary setting: erased value open, programming clears bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_ff <= PROTECT_RESET;
        end else if (wr_prot && tv) begin
            protect_ff <= pwdata[7:0];
        end else if (prog_go && (wr_addr == BOUNDARY_ADDR)) begin
            protect_ff <= protect_ff & pwdata[AW_DATA_LSB +: 8];
        end
    end

    // array control levels
    assign pump_on = hv_ff;
    assign hv_to_array = hv_ff;
    assign erase_page_en = hv_ff && erase_ff && !mass_ff;
    assign erase_mass_en = hv_ff && erase_ff && mass_ff && !mass_inhibit;
    assign trim_erase = hv_ff && erase_ff && ((mass_ff && !mass_inhibit) || vec_page_ff);
    assign program_en = hv_ff && program_ff;
    assign standby = !(program_ff || erase_ff || hv_ff);
    assign prog_strobe = prog_strobe_ff;
    assign array_addr = array_addr_ff;
    assign array_data = array_data_ff;

    // read data, captured in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == FLASH_OP_CONTROL_OFS) begin
            rd_mux[CTRL_PROGRAM_SELECT_BIT] = program_ff;
            rd_mux[CTRL_ERASE_SELECT_BIT] = erase_ff;
            rd_mux[CTRL_MASS_SELECT_BIT] = mass_ff;
            rd_mux[CTRL_HIGH_VOLTAGE_ON_BIT] = hv_ff;
        end else if (paddr == PROTECT_START_SETTING_OFS) begin
            rd_mux[7:0] = protect_ff;
        end else if (paddr == OP_STATUS_OFS) begin
            rd_mux[ST_TARGET_LSB +: 16] = target_ff;
            rd_mux[ST_STATE_LSB +: 3] = state_ff;
            rd_mux[ST_TARGET_PROT_BIT] = target_prot;
            rd_mux[ST_MASS_INHIBIT_BIT] = mass_inhibit;
            rd_mux[ST_STANDBY_BIT] = standby;
        end else if (paddr == ELAPSED_OFS) begin
            rd_mux[TMR_W-1:0] = elapsed;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata = prdata_ff;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_hv_rise;
        $rose(hv_ff);
    endsequence
    sequence s_armed_entry;
        (state_ff == ST_PROT_READ) ##1 (state_ff == ST_ARMED);
    endsequence

    property p_sel_exclusive;
        !(program_ff && erase_ff);
    endproperty
    a_sel_exclusive: assert property (p_sel_exclusive)
        else $error("program and erase select both set");

    property p_hv_prepared;
        s_hv_rise |-> $past(state_ff == ST_ARMED) && (program_ff || erase_ff);
    endproperty
    a_hv_prepared: assert property (p_hv_prepared)
        else $error("high voltage set without preparation");

    property p_hv_after_nvs;
        s_hv_rise |-> $past(elapsed) >= NVS_CYC;
    endproperty
    a_hv_after_nvs: assert property (p_hv_after_nvs)
        else $error("high voltage set before select delay");

    property p_hv_not_protected;
        s_hv_rise |-> !$past(target_prot);
    endproperty
    a_hv_not_protected: assert property (p_hv_not_protected)
        else $error("high voltage set on protected target");

    property p_mass_inhibit;
        erase_mass_en |-> (protect_ff == PROTECT_OPEN) && trim_erase;
    endproperty
    a_mass_inhibit: assert property (p_mass_inhibit)
        else $error("mass erase while protected or trim kept");

    property p_lowpower_abort;
        lp |=> standby && !prog_strobe && (state_ff == ST_IDLE);
    endproperty
    a_lowpower_abort: assert property (p_lowpower_abort)
        else $error("low power did not abort operation");

    property p_strobe_row;
        prog_strobe |-> (array_addr[15:ROW_LSB] == target_ff[15:ROW_LSB]) && program_en;
    endproperty
    a_strobe_row: assert property (p_strobe_row)
        else $error("program strobe outside latched row");

    property p_strobe_after_pgs;
        prog_strobe |-> $past(elapsed) >= PGS_CYC;
    endproperty
    a_strobe_after_pgs: assert property (p_strobe_after_pgs)
        else $error("program byte before first write delay");

    property p_dummy_no_change;
        s_armed_entry |-> !prog_strobe && !hv_ff && (target_ff == $past(wr_addr));
    endproperty
    a_dummy_no_change: assert property (p_dummy_no_change)
        else $error("dummy write altered array or missed target");

    property p_open_setting;
        (protect_ff == PROTECT_OPEN) |-> !target_prot && !mass_inhibit;
    endproperty
    a_open_setting: assert property (p_open_setting)
        else $error("all ones setting still protects");
endmodule : fpe_flash_ctrl
`default_nettype wire

/* include/fpe_pkg.sv */
`default_nettype none
package fpe_pkg;
    // bus clock and time conversion
    localparam int unsigned BUS_CLK_KHZ = 50000;
    localparam int unsigned SEL_TO_HV_DELAY_US = 10;
    localparam int unsigned HV_TO_FIRST_WRITE_DELAY_US = 5;

    function automatic int unsigned fpe_us_to_cyc(input int unsigned us, input int unsigned khz);
        int unsigned cyc;
        cyc = (us * khz + 999) / 1000;
        return (cyc < 1) ? 1 : cyc;
    endfunction : fpe_us_to_cyc

    localparam int unsigned TMR_W = 18;
    localparam int unsigned SEL_TO_HV_CYC = fpe_us_to_cyc(SEL_TO_HV_DELAY_US, BUS_CLK_KHZ);
    localparam int unsigned HV_TO_FIRST_WRITE_CYC =
        fpe_us_to_cyc(HV_TO_FIRST_WRITE_DELAY_US, BUS_CLK_KHZ);

    // apb register map, byte addresses
    localparam int unsigned APB_ADDR_W = 12;
    localparam logic [11:0] FLASH_OP_CONTROL_OFS = 12'h000;
    localparam logic [11:0] PROTECT_START_SETTING_OFS = 12'h004;
    localparam logic [11:0] ARRAY_WRITE_OFS = 12'h008;
    localparam logic [11:0] OP_STATUS_OFS = 12'h00c;
    localparam logic [11:0] ELAPSED_OFS = 12'h010;

    // flash_op_control fields
    localparam int unsigned CTRL_PROGRAM_SELECT_BIT = 0;
    localparam int unsigned CTRL_ERASE_SELECT_BIT = 1;
    localparam int unsigned CTRL_MASS_SELECT_BIT = 2;
    localparam int unsigned CTRL_HIGH_VOLTAGE_ON_BIT = 3;

    // array write fields
    localparam int unsigned AW_DATA_LSB = 0;
    localparam int unsigned AW_ADDR_LSB = 8;

    // op status fields
    localparam int unsigned ST_TARGET_LSB = 0;
    localparam int unsigned ST_STATE_LSB = 16;
    localparam int unsigned ST_TARGET_PROT_BIT = 19;
    localparam int unsigned ST_MASS_INHIBIT_BIT = 20;
    localparam int unsigned ST_STANDBY_BIT = 21;

    // protection and array geometry
    localparam logic [7:0] PROTECT_RESET = 8'hff;
    localparam logic [7:0] PROTECT_OPEN = 8'hff;
    localparam logic [7:0] PROTECT_ALL_MAX = 8'hb8;
    localparam logic [1:0] PROTECT_ADDR_HI = 2'h3;
    localparam logic [15:0] VECTOR_PAGE_BASE = 16'hffd0;
    localparam logic [15:0] BOUNDARY_ADDR_DEF = 16'hffbe;
    localparam int unsigned PAGE_LSB = 6;
    localparam int unsigned ROW_LSB = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SELECTED = 3'b001,
        ST_PROT_READ = 3'b010,
        ST_ARMED = 3'b011,
        ST_HV_ON = 3'b100
    } fpe_state_t;
endpackage : fpe_pkg
`default_nettype wire

/* rtl/fpe_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fpe_interval_timer #(
    parameter int unsigned W = fpe_pkg::TMR_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic restart,
    // elapsed cycles
    output logic [W-1:0] count
);
    import fpe_pkg::*;

    logic [W-1:0] count_ff;

    // saturating cycle count since restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else if (restart) begin
            count_ff <= '0;
        end else if (count_ff != {W{1'b1}}) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign count = count_ff;
endmodule : fpe_interval_timer
`default_nettype wire

/* rtl/fpe_protect_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module fpe_protect_decode #(
    parameter logic [15:0] BOUNDARY_ADDR = fpe_pkg::BOUNDARY_ADDR_DEF
) (
    // setting and address
    input wire logic [7:0] protect_start_bits,
    input wire logic [15:0] addr,
    input wire logic test_hv,
    // verdicts
    output logic addr_protected,
    output logic mass_inhibit
);
    import fpe_pkg::*;

    logic [15:0] start_addr;
    logic any_protect;

    assign start_addr = {PROTECT_ADDR_HI, protect_start_bits, 6'h00};
    assign any_protect = (protect_start_bits != PROTECT_OPEN);
    assign mass_inhibit = any_protect;
    // boundary byte and range locked unless setting open or test voltage
    assign addr_protected = any_protect && !test_hv &&
        ((protect_start_bits <= PROTECT_ALL_MAX) || (addr >= start_addr) ||
        (addr == BOUNDARY_ADDR));
endmodule : fpe_protect_decode
`default_nettype wire

/* dv/flash_program_erase_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_tb;
    import fpe_pkg::*;
    localparam int unsigned KHZ = 5000;
    localparam int unsigned SEL_CYC = 50;
    localparam int unsigned HV_CYC = 25;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} fpe_rd_t;
    typedef struct {logic [7:0] s; logic [3:0] c; logic [15:0] a; logic t;} fpe_op_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic lowpower_req, test_high_voltage, pump_on, hv_to_array, erase_page_en;
    logic erase_mass_en, trim_erase, program_en, prog_strobe, standby;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] array_addr, a;
    logic [7:0] array_data, d;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 72297;
    fpe_rd_t rq[$];
    logic [23:0] sq[$];
    fpe_rd_t re;
    logic [23:0] se;
    logic [4:0] offs[3] = '{5'h1f, 5'h00, 5'h0a};
    fpe_op_t ops[10] = '{'{8'hff, 4'h6, 16'hf805, 1'b0}, '{8'hff, 4'h2, 16'hffd0, 1'b0},
        '{8'hbc, 4'h2, 16'heec7, 1'b0}, '{8'hbc, 4'h2, 16'hef00, 1'b0},
        '{8'hbc, 4'h2, 16'hef00, 1'b1}, '{8'hbc, 4'h6, 16'hf800, 1'b1},
        '{8'hb8, 4'h2, 16'hfc00, 1'b0}, '{8'hb9, 4'h2, 16'hee3f, 1'b0},
        '{8'hb9, 4'h1, 16'hee40, 1'b0}, '{8'h00, 4'h1, 16'hee00, 1'b0}};

    fpe_flash_ctrl #(.CLK_KHZ(KHZ)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lowpower_req(lowpower_req),
        .test_high_voltage(test_high_voltage), .pump_on(pump_on), .hv_to_array(hv_to_array),
        .erase_page_en(erase_page_en), .erase_mass_en(erase_mass_en), .trim_erase(trim_erase),
        .program_en(program_en), .prog_strobe(prog_strobe), .array_addr(array_addr),
        .array_data(array_data), .standby(standby));

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    task test_done;
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task bad(input string m);
        fail_count++;
        $display("BAD %0t %s", $time, m);
    endtask : bad

    task chk(input logic [23:0] g, input logic [23:0] e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask : chk

    task cmp_read(input fpe_rd_t e);
        n_compared++;
        if ((prdata & e.mask) !== (e.data & e.mask) || pslverr !== e.err) bad("read data");
    endtask : cmp_read

    task cmp_strobe(input logic [23:0] e);
        n_compared++;
        if ({array_addr, array_data} !== e) bad("programmed byte");
    endtask : cmp_strobe

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task apb(input logic w, input logic [11:0] ad, input logic [31:0] dt);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad("apb timeout");
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] ad, input logic [31:0] dt);
        apb(1'b1, ad, dt);
    endtask : wr

    task rd(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] m, input logic er);
        rq.push_back(fpe_rd_t'{e, m, er});
        apb(1'b0, ad, 32'h0);
    endtask : rd

    task do_op(input fpe_op_t o);
        logic [15:0] start;
        logic prot, ok;
        start = {2'b11, o.s, 6'h00};
        prot = (o.s != 8'hff) && (o.s <= 8'hb8 || o.a >= start);
        ok = (!prot || o.t) && !(o.c[2] && o.s != 8'hff);
        test_high_voltage <= 1'b1;
        cyc(4);
        wr(12'h004, {24'h0, o.s});
        rd(12'h004, {24'h0, o.s}, 32'hff, 1'b0);
        test_high_voltage <= o.t;
        cyc(4);
        wr(12'h000, {28'h0, o.c});
        rd(12'h004, {24'h0, o.s}, 32'hff, 1'b0);
        wr(12'h008, {8'h0, o.a, 8'h5a});
        rd(12'h00c, {11'h0, o.s != 8'hff, prot, 3'h3, 16'h0},
            o.t ? 32'h0017_0000 : 32'h001f_0000, 1'b0);
        chk(array_addr, o.c[0] ? {o.a[15:5], 5'h00} : (o.a >= 16'hffd0) ? 16'hffd0 :
            {o.a[15:6], 6'h00}, "page or row base");
        cyc(SEL_CYC + 5);
        wr(12'h000, {28'h0, 1'b1, o.c[2:0]});
        rd(12'h000, {28'h0, ok, o.c[2:0]}, 32'hf, 1'b0);
        cyc(1);
        chk(pump_on, ok, "pump");
        chk(hv_to_array, ok, "array voltage");
        chk(erase_page_en, ok && o.c == 4'h2, "page erase");
        chk(erase_mass_en, ok && o.c[2], "mass erase");
        chk(trim_erase, ok && (o.c[2] || o.a >= 16'hffd0), "trim erase");
        chk(program_en, ok && o.c == 4'h1, "program");
        wr(12'h000, 32'h8);
        cyc(1);
        chk(pump_on, ok, "voltage held after deselect");
        chk(erase_page_en | erase_mass_en, 1'b0, "erase after deselect");
        cyc(o.c[2] ? 500 : 25);
        wr(12'h000, 32'h0);
        cyc(1);
        chk(standby, 1'b1, "standby");
        test_high_voltage <= 1'b0;
        cyc(1);
    endtask : do_op

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (rq.size() == 0) begin
                bad("unexpected read");
            end else begin
                re = rq.pop_front();
                cmp_read(re);
            end
        end
        if (prog_strobe === 1'b1) begin
            if (sq.size() == 0) begin
                bad("unexpected program strobe");
            end else begin
                se = sq.pop_front();
                cmp_strobe(se);
            end
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, lowpower_req, test_high_voltage} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'h0, 32'hf, 1'b0);
        rd(12'h004, 32'hff, 32'hff, 1'b0);
        rd(12'h00c, 32'h0020_0000, 32'h003f_0000, 1'b0);
        rd(12'h014, 32'h0, 32'hffff_ffff, 1'b1);
        chk(array_data, 8'hff, "array data reset");
        wr(12'h000, 32'h3);
        rd(12'h000, 32'h0, 32'hf, 1'b0);
        wr(12'h000, 32'h8);
        rd(12'h000, 32'h0, 32'hf, 1'b0);
        wr(12'h000, 32'h1);
        rd(12'h004, 32'hff, 32'hff, 1'b0);
        wr(12'h008, {8'h0, 16'hf827, 8'h00});
        cyc(1);
        chk(array_addr, 16'hf820, "row base");
        wr(12'h000, 32'h9);
        rd(12'h000, 32'h1, 32'hf, 1'b0);
        cyc(SEL_CYC + 5);
        wr(12'h000, 32'h9);
        rd(12'h000, 32'h9, 32'hf, 1'b0);
        cyc(1);
        chk(program_en, 1'b1, "program enable");
        chk(pump_on, 1'b1, "pump on");
        chk(standby, 1'b0, "active");
        cyc(HV_CYC + 5);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            a = (i == 3) ? 16'hf840 : {11'h7c1, offs[i % 3]};
            if (i < 3) sq.push_back({a, d});
            wr(12'h008, {8'h0, a, d});
            cyc(3 * SEL_CYC + 10);
        end
        lowpower_req <= 1'b1;
        cyc(5);
        chk(standby, 1'b1, "standby on wait");
        chk(pump_on, 1'b0, "pump off on wait");
        chk(program_en, 1'b0, "program off on wait");
        rd(12'h000, 32'h0, 32'hf, 1'b0);
        lowpower_req <= 1'b0;
        cyc(4);
        wr(12'h000, 32'h1);
        rd(12'h004, 32'hff, 32'hff, 1'b0);
        wr(12'h008, {8'h0, BOUNDARY_ADDR_DEF, 8'h00});
        cyc(SEL_CYC + 5);
        wr(12'h000, 32'h9);
        cyc(HV_CYC + 5);
        sq.push_back({BOUNDARY_ADDR_DEF, 8'hc3});
        wr(12'h008, {8'h0, BOUNDARY_ADDR_DEF, 8'hc3});
        cyc(2);
        rd(12'h004, 32'hc3, 32'hff, 1'b0);
        wr(12'h000, 32'h8);
        cyc(HV_CYC);
        wr(12'h000, 32'h0);
        cyc(4);
        foreach (ops[i]) do_op(ops[i]);
        cyc(5);
        if (rq.size() != 0 || sq.size() != 0) bad("missing results");
        test_done();
    end
endmodule : flash_program_erase_control_tb
`default_nettype wire
